// ---- design/msc_pkg.sv ----
package msc_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CMD     = 8'h00;
    localparam logic [7:0] OFS_STAT1   = 8'h04;
    localparam logic [7:0] OFS_STAT2   = 8'h08;
    localparam logic [7:0] OFS_RT_EN   = 8'h0c;
    localparam logic [7:0] OFS_PHASE   = 8'h10;
    localparam logic [7:0] OFS_AXIS    = 8'h14;
    localparam logic [7:0] OFS_SEQ     = 8'h18;
    localparam logic [7:0] OFS_ACC     = 8'h1c;
    localparam logic [7:0] OFS_DEPTH   = 8'h20;
    localparam logic [7:0] OFS_CFG     = 8'h24;
    // command opcodes, cmd word bits [7:0]
    localparam logic [7:0] OP_WIPE     = 8'h01;
    localparam logic [7:0] OP_FLUSH    = 8'h02;
    localparam logic [7:0] OP_POWER    = 8'h03;
    localparam logic [7:0] OP_RT_EXIT  = 8'h04;
    localparam logic [7:0] OP_LOAD     = 8'h05;
    localparam logic [7:0] OP_EXIT     = 8'h06;
    localparam logic [7:0] OP_RT_OFF   = 8'h07;
    localparam logic [7:0] OP_RT_ON    = 8'h08;
    localparam logic [7:0] OP_REBOOT   = 8'h09;
    localparam logic [7:0] OP_CLR_ERR  = 8'h0a;
    localparam logic [7:0] OP_STORE    = 8'h0b;
    localparam logic [7:0] OP_CALL     = 8'h0c;
    // option values, reboot key and error handler label
    localparam logic [15:0] OPT_0      = 16'h0000;
    localparam logic [15:0] OPT_1      = 16'h0001;
    localparam logic [15:0] OPT_2      = 16'h0002;
    localparam logic [15:0] REBOOT_KEY = 16'h00ff;
    localparam logic [15:0] ERR_LABEL  = 16'h0050;
    // transfer item mask: seq,lut,var,par,trig,rti,float,axis
    localparam logic [7:0] MASK_ALL    = 8'hff;
    localparam logic [7:0] MASK_SEQLUT = 8'h03;
    localparam logic [7:0] MASK_CFG    = 8'hfc;
    localparam logic [7:0] MASK_NONE   = 8'h00;
    // status bit positions
    localparam int unsigned S1_BUSY    = 0;
    localparam int unsigned S1_ERR     = 10;
    localparam int unsigned S2_PEND    = 0;
    localparam int unsigned S2_OVF     = 1;
    localparam int unsigned S2_HANDLER = 2;
    // reset values, stack depth and controller states
    localparam logic [7:0] AXIS_RST    = 8'h00;
    localparam logic [7:0] PHASE_RST   = 8'h00;
    localparam int unsigned STACK_DEPTH = 256;
    typedef enum logic [0:0] {ST_IDLE, ST_XFER} msc_state_t;
endpackage : msc_pkg

// ---- design/msc_stack_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface msc_stack_if #(parameter int unsigned CW = 9);
    logic          push;
    logic          pop;
    logic          flush;
    logic [15:0]   push_line;
    logic [31:0]   push_acc;
    logic [15:0]   top_line;
    logic [31:0]   top_acc;
    logic [CW-1:0] count;
    logic          full;
    logic          empty;
    modport ctl (output push, pop, flush, push_line, push_acc,
                 input top_line, top_acc, count, full, empty);
    modport stk (input push, pop, flush, push_line, push_acc,
                 output top_line, top_acc, count, full, empty);
endinterface : msc_stack_if
`default_nettype wire

// ---- design/msc_stack.sv ----
`timescale 1ns/1ns
`default_nettype none
module msc_stack #(
    parameter int unsigned DEPTH = 256,
    parameter int unsigned CW    = 9
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    msc_stack_if.stk  s
);
    logic [47:0]   mem [DEPTH];
    logic [CW-1:0] cnt_r;
    wire  [CW-1:0] idx_w = cnt_r - 1'b1;

    assign s.count    = cnt_r;
    assign s.full     = (cnt_r == CW'(DEPTH));
    assign s.empty    = (cnt_r == '0);
    assign s.top_line = mem[idx_w[CW-2:0]][47:32];
    assign s.top_acc  = mem[idx_w[CW-2:0]][31:0];

    always_ff @(posedge clk_i) begin
        if (s.push && !s.full && !s.flush && !s.pop) begin
            mem[cnt_r[CW-2:0]] <= {s.push_line, s.push_acc};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= '0;
        end else if (s.flush) begin
            cnt_r <= '0;
        end else if (s.pop && !s.empty) begin
            cnt_r <= idx_w;
        end else if (s.push && !s.full) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule : msc_stack
`default_nettype wire

// ---- design/msc_exec.sv ----
`timescale 1ns/1ns
`default_nettype none
// Contract
// - wipe command restores default parameters and clears sequence, chosen by option.
// - wipe option 0 does both, 1 clears sequence, 2 loads defaults.
// - stack flush discards every call stack level at once.
// - calls and error handler entry push the current line; 256 entries.
// - on error mode, continue at the error handler label if present.
// - power command 1 switches on, 0 off; first on starts phasing.
// - power off followed by power on clears the error state.
// - realtime on and exit happen together in one indivisible step.
// - load option 0 copies all; config items only when all switches read 1.
// - load option 1 copies only sequences and lookup table.
// - load option 2 copies config items when all switches read 1.
// - exit pops the return point and restores the accumulator.
// - realtime off disables; writing 0 to realtime enable does the same.
// - realtime on enables; writing 1 to realtime enable does the same.
// - hard reboot resets the controller only for argument 255.
// - clear errors resets error flag, bit 10 of status word one.
// - clear errors inside handler also clears pending bit 0 of word two.
// - store writes current ram contents into flash per option.
// - store option 0 all, 1 sequences and table, 2 config items.
module msc_exec #(
    parameter int unsigned DIP_W = 4,
    parameter int unsigned DEPTH = msc_pkg::STACK_DEPTH
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [DIP_W-1:0] dip_i,
    input  wire logic        err_event_i,
    input  wire logic        xfer_done_i,
    output logic             seq_clear_o,
    output logic             dflt_load_o,
    output logic             xfer_req_o,
    output logic             xfer_to_flash_o,
    output logic      [7:0]  xfer_mask_o,
    output logic             power_en_o,
    output logic             phasing_start_o,
    output logic      [7:0]  phasing_mode_o,
    output logic             realtime_en_o,
    output logic             hard_reset_o,
    output logic      [15:0] seq_line_o
);
    localparam int unsigned CW = $clog2(DEPTH) + 1;

    msc_stack_if #(.CW(CW)) sif ();
    msc_stack #(.DEPTH(DEPTH), .CW(CW)) u_stack (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .s     (sif.stk)
    );

    msc_pkg::msc_state_t state_r;
    logic [DIP_W-1:0] dip_s1_r;
    logic [DIP_W-1:0] dip_s2_r;
    logic [7:0]  axis_r;
    logic [15:0] seq_r;
    logic [31:0] acc_r;
    logic        err_r;
    logic        pend_r;
    logic        ovf_r;
    logic        in_hdl_r;
    logic        hdl_present_r;
    logic        phased_r;
    logic        off_seen_r;

    // bus decode: a write acts on the first cycle, ack follows
    wire req_w   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr_w    = req_w & wb_we_i & (wb_sel_i == 4'hf);
    wire [7:0]  op_w   = wb_dat_i[7:0];
    wire [7:0]  cax_w  = wb_dat_i[15:8];
    wire [15:0] p1_w   = wb_dat_i[31:16];
    wire cmd_wr_w = wr_w & (wb_adr_i == msc_pkg::OFS_CMD);
    wire idle_w   = (state_r == msc_pkg::ST_IDLE);
    wire cmd_go   = cmd_wr_w & (cax_w == axis_r) & idle_w;

    wire go_wipe   = cmd_go & (op_w == msc_pkg::OP_WIPE);
    wire go_flush  = cmd_go & (op_w == msc_pkg::OP_FLUSH);
    wire go_pwr    = cmd_go & (op_w == msc_pkg::OP_POWER);
    wire go_rtexit = cmd_go & (op_w == msc_pkg::OP_RT_EXIT);
    wire go_load   = cmd_go & (op_w == msc_pkg::OP_LOAD);
    wire go_exit   = cmd_go & (op_w == msc_pkg::OP_EXIT);
    wire go_rtoff  = cmd_go & (op_w == msc_pkg::OP_RT_OFF);
    wire go_rton   = cmd_go & (op_w == msc_pkg::OP_RT_ON);
    wire go_reboot = cmd_go & (op_w == msc_pkg::OP_REBOOT);
    wire go_clr    = cmd_go & (op_w == msc_pkg::OP_CLR_ERR);
    wire go_store  = cmd_go & (op_w == msc_pkg::OP_STORE);
    wire go_call   = cmd_go & (op_w == msc_pkg::OP_CALL);

    wire opt0 = (p1_w == msc_pkg::OPT_0);
    wire opt1 = (p1_w == msc_pkg::OPT_1);
    wire opt2 = (p1_w == msc_pkg::OPT_2);

    wire wipe_seq_w  = go_wipe & (opt0 | opt1);
    wire wipe_dflt_w = go_wipe & (opt0 | opt2);

    // config items are loaded only with every dip switch at 1; store ignores the switches
    wire dip_ok_w = &dip_s2_r;
    wire [7:0] ld_mask_w = opt0 ? (dip_ok_w ? msc_pkg::MASK_ALL : msc_pkg::MASK_SEQLUT) :
                           opt1 ? msc_pkg::MASK_SEQLUT :
                           opt2 ? (dip_ok_w ? msc_pkg::MASK_CFG : msc_pkg::MASK_NONE) :
                           msc_pkg::MASK_NONE;
    wire [7:0] st_mask_w = opt0 ? msc_pkg::MASK_ALL :
                           opt1 ? msc_pkg::MASK_SEQLUT :
                           opt2 ? msc_pkg::MASK_CFG : msc_pkg::MASK_NONE;
    wire ld_start_w = go_load & (ld_mask_w != msc_pkg::MASK_NONE);
    wire st_start_w = go_store & (st_mask_w != msc_pkg::MASK_NONE);

    // error entry takes priority; a call in the same cycle is lost
    wire err_go_w  = err_event_i & hdl_present_r;
    wire call_w    = go_call & ~err_go_w;
    wire pop_w     = go_exit | go_rtexit;
    wire ovf_w     = (err_go_w | call_w) & sif.full;
    wire pushed_w  = (err_go_w | call_w) & ~sif.full;
    wire popped_w  = pop_w & ~sif.empty;

    assign sif.push      = err_go_w | call_w;
    assign sif.pop       = pop_w;
    assign sif.flush     = go_flush;
    assign sif.push_line = seq_r;
    assign sif.push_acc  = acc_r;

    wire on_w   = go_pwr & opt1;
    wire off_w  = go_pwr & opt0;
    wire pclr_w = on_w & off_seen_r;

    wire bw_rt    = wr_w & (wb_adr_i == msc_pkg::OFS_RT_EN);
    wire bw_phase = wr_w & (wb_adr_i == msc_pkg::OFS_PHASE);
    wire bw_axis  = wr_w & (wb_adr_i == msc_pkg::OFS_AXIS);
    wire bw_seq   = wr_w & (wb_adr_i == msc_pkg::OFS_SEQ);
    wire bw_acc   = wr_w & (wb_adr_i == msc_pkg::OFS_ACC);
    wire bw_cfg   = wr_w & (wb_adr_i == msc_pkg::OFS_CFG);

    wire [31:0] stat1_w = (32'(err_r) << msc_pkg::S1_ERR) |
                          (32'(!idle_w) << msc_pkg::S1_BUSY);
    wire [31:0] stat2_w = (32'(pend_r) << msc_pkg::S2_PEND) |
                          (32'(ovf_r) << msc_pkg::S2_OVF) |
                          (32'(in_hdl_r) << msc_pkg::S2_HANDLER);
    wire [7:0] a_w = wb_adr_i;
    wire [31:0] rd_w = (a_w == msc_pkg::OFS_STAT1) ? stat1_w :
                       (a_w == msc_pkg::OFS_STAT2) ? stat2_w :
                       (a_w == msc_pkg::OFS_RT_EN) ? {31'h0, realtime_en_o} :
                       (a_w == msc_pkg::OFS_PHASE) ? {24'h0, phasing_mode_o} :
                       (a_w == msc_pkg::OFS_AXIS)  ? {24'h0, axis_r} :
                       (a_w == msc_pkg::OFS_SEQ)   ? {16'h0, seq_r} :
                       (a_w == msc_pkg::OFS_ACC)   ? acc_r :
                       (a_w == msc_pkg::OFS_DEPTH) ? 32'(sif.count) :
                       (a_w == msc_pkg::OFS_CFG)   ? {31'h0, hdl_present_r} :
                       32'h0;

    assign seq_line_o = seq_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= req_w;
            wb_dat_o <= req_w ? rd_w : 32'h0;
        end
    end

    // two flops before the dip switch pins reach any logic
    always_ff @(posedge clk_i) begin
        dip_s1_r <= dip_i;
        dip_s2_r <= dip_s1_r;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq_clear_o     <= 1'b0;
            dflt_load_o     <= 1'b0;
            hard_reset_o    <= 1'b0;
            phasing_start_o <= 1'b0;
        end else begin
            seq_clear_o     <= wipe_seq_w;
            dflt_load_o     <= wipe_dflt_w;
            hard_reset_o    <= go_reboot & (p1_w == msc_pkg::REBOOT_KEY);
            phasing_start_o <= on_w & ~phased_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r         <= msc_pkg::ST_IDLE;
            xfer_req_o      <= 1'b0;
            xfer_to_flash_o <= 1'b0;
            xfer_mask_o     <= msc_pkg::MASK_NONE;
        end else begin
            case (state_r)
                msc_pkg::ST_IDLE: begin
                    if (ld_start_w | st_start_w) begin
                        state_r         <= msc_pkg::ST_XFER;
                        xfer_req_o      <= 1'b1;
                        xfer_to_flash_o <= st_start_w;
                        xfer_mask_o     <= st_start_w ? st_mask_w : ld_mask_w;
                    end
                end
                msc_pkg::ST_XFER: begin
                    if (xfer_done_i) begin
                        state_r    <= msc_pkg::ST_IDLE;
                        xfer_req_o <= 1'b0;
                    end
                end
                default: begin
                    state_r    <= msc_pkg::ST_IDLE;
                    xfer_req_o <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_en_o <= 1'b0;
            phased_r   <= 1'b0;
            off_seen_r <= 1'b0;
        end else begin
            power_en_o <= on_w ? 1'b1 : off_w ? 1'b0 : power_en_o;
            phased_r   <= phased_r | on_w;
            off_seen_r <= off_w ? 1'b1 : on_w ? 1'b0 : off_seen_r;
        end
    end

    // sticky flags: a hardware set beats a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_r  <= 1'b0;
            pend_r <= 1'b0;
            ovf_r  <= 1'b0;
        end else begin
            err_r  <= (err_event_i | ovf_w) ? 1'b1 :
                      (go_clr | pclr_w) ? 1'b0 : err_r;
            pend_r <= err_event_i ? 1'b1 :
                      (go_clr & in_hdl_r) ? 1'b0 : pend_r;
            ovf_r  <= ovf_w ? 1'b1 : go_clr ? 1'b0 : ovf_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq_r    <= 16'h0;
            acc_r    <= 32'h0;
            in_hdl_r <= 1'b0;
        end else begin
            if (err_go_w & pushed_w) begin
                seq_r <= msc_pkg::ERR_LABEL;
            end else if (call_w & pushed_w) begin
                seq_r <= p1_w;
            end else if (popped_w) begin
                seq_r <= sif.top_line;
            end else if (bw_seq) begin
                seq_r <= wb_dat_i[15:0];
            end
            if (popped_w) begin
                acc_r <= sif.top_acc;
            end else if (bw_acc) begin
                acc_r <= wb_dat_i;
            end
            in_hdl_r <= (err_go_w & pushed_w) ? 1'b1 : pop_w ? 1'b0 : in_hdl_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            realtime_en_o  <= 1'b0;
            phasing_mode_o <= msc_pkg::PHASE_RST;
            axis_r         <= msc_pkg::AXIS_RST;
            hdl_present_r  <= 1'b0;
        end else begin
            if (go_rton | go_rtexit) begin
                realtime_en_o <= 1'b1;
            end else if (go_rtoff) begin
                realtime_en_o <= 1'b0;
            end else if (bw_rt) begin
                realtime_en_o <= wb_dat_i[0];
            end
            if (bw_phase) begin
                phasing_mode_o <= wb_dat_i[7:0];
            end
            if (bw_axis) begin
                axis_r <= wb_dat_i[7:0];
            end
            if (bw_cfg) begin
                hdl_present_r <= wb_dat_i[0];
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_wipe0;
        go_wipe && opt0 |=> seq_clear_o && dflt_load_o;
    endproperty
    a_wipe0: assert property (p_wipe0) else $error("wipe 0 missed");

    property p_flush;
        go_flush |=> sif.count == '0;
    endproperty
    a_flush: assert property (p_flush) else $error("stack not flushed");

    property p_push;
        call_w && !sif.full |=> sif.count == $past(sif.count) + 1'b1;
    endproperty
    a_push: assert property (p_push) else $error("push lost");

    sequence s_err_entry;
        err_go_w && !sif.full;
    endsequence
    property p_err_entry;
        s_err_entry |=> seq_r == msc_pkg::ERR_LABEL ##0 in_hdl_r;
    endproperty
    a_err_entry: assert property (p_err_entry) else $error("no handler entry");

    property p_phase;
        on_w && !phased_r |=> phasing_start_o ##1 !phasing_start_o;
    endproperty
    a_phase: assert property (p_phase) else $error("phasing not started");

    property p_reboot;
        hard_reset_o |-> $past(p1_w) == msc_pkg::REBOOT_KEY && $past(go_reboot);
    endproperty
    a_reboot: assert property (p_reboot) else $error("bad reboot");

    property p_clr;
        go_clr && !err_event_i && !ovf_w |=> !err_r;
    endproperty
    a_clr: assert property (p_clr) else $error("error not cleared");

    property p_axis;
        cmd_wr_w && cax_w != axis_r |-> !cmd_go;
    endproperty
    a_axis: assert property (p_axis) else $error("foreign axis run");

    property p_ovf;
        ovf_w |=> err_r && ovf_r && sif.count == $past(sif.count);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not refused");
endmodule : msc_exec
`default_nettype wire

// ---- bench/msc_mover.sv ----
`timescale 1ns/1ns
`default_nettype none
// ram/flash mover model: one done pulse per request, alternately fast and slow
module msc_mover (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic xfer_req_i,
    output logic      xfer_done_o
);
    logic [3:0] cnt_r;
    logic       slow_r;
    logic       sent_r;
    // done only once per request, since req stays high one cycle past it
    always_ff @(posedge clk_i) begin
        xfer_done_o <= 1'b0;
        if (rst_i) begin
            slow_r <= 1'b0;
        end
        if (rst_i || !xfer_req_i) begin
            cnt_r  <= 4'h0;
            sent_r <= 1'b0;
        end else if (!sent_r) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == (slow_r ? 4'h6 : 4'h0)) begin
                xfer_done_o <= 1'b1;
                sent_r      <= 1'b1;
                slow_r      <= !slow_r;
            end
        end
    end
endmodule : msc_mover
`default_nettype wire

// ---- bench/tb_motion_sequence_command_executor.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_motion_sequence_command_executor;
    logic        clk_i, rst_i, cyc, stb, we, ack, err_ev, done;
    logic [7:0]  adr, axis, mask, ph_mode;
    logic [3:0]  sel_v, dip, snap;
    logic [31:0] wdat, rdat;
    logic [9:0]  xsnap;
    logic        seq_clr, dflt, xreq, xflash, power_switch_cmd, ph_start, rt_en, hrst;
    logic [15:0] seq_line;
    int          mismatches, num_checks;

    msc_exec #(.DIP_W(4), .DEPTH(4)) msc_exec_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel_v), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .dip_i(dip), .err_event_i(err_ev), .xfer_done_i(done), .seq_clear_o(seq_clr),
        .dflt_load_o(dflt), .xfer_req_o(xreq), .xfer_to_flash_o(xflash), .xfer_mask_o(mask),
        .power_en_o(power_switch_cmd), .phasing_start_o(ph_start), .phasing_mode_o(ph_mode),
        .realtime_en_o(rt_en), .hard_reset_o(hrst), .seq_line_o(seq_line));
    msc_mover msc_mover_inst (.clk_i(clk_i), .rst_i(rst_i), .xfer_req_i(xreq), .xfer_done_o(done));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic results;
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // pulses only live in the ack cycle, so they are captured at the ack edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            mismatches++;
            results();
        end
        q = rdat;
        snap = {seq_clr, dflt, ph_start, hrst};
        xsnap = {xreq, xflash, mask};
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask : rd

    task automatic cmd(input logic [7:0] op, input logic [15:0] p);
        wr(msc_pkg::OFS_CMD, {p, axis, op});
    endtask : cmd

    task automatic err_pulse;
        @(posedge clk_i);
        err_ev <= 1'b1;
        @(posedge clk_i);
        err_ev <= 1'b0;
        // let the entry settle before anyone looks at it
        @(posedge clk_i);
    endtask : err_pulse

    task automatic t_regs;
        rd(msc_pkg::OFS_STAT1, 32'h0);
        rd(8'h3c, 32'h0);
        wr(msc_pkg::OFS_PHASE, 32'h5a);
        chk(ph_mode, 8'h5a);
        sel_v <= 4'h3;
        wr(msc_pkg::OFS_PHASE, 32'h11);
        sel_v <= 4'hf;
        rd(msc_pkg::OFS_PHASE, 32'h5a);
        wr(msc_pkg::OFS_RT_EN, 32'h1);
        chk(rt_en, 1'b1);
        wr(msc_pkg::OFS_RT_EN, 32'h0);
        chk(rt_en, 1'b0);
    endtask : t_regs

    task automatic t_wipe;
        for (int i = 0; i < 4; i++) begin
            cmd(msc_pkg::OP_WIPE, i[15:0]);
            chk(snap, {i == 0 || i == 1, i == 0 || i == 2, 2'b00});
        end
    endtask : t_wipe

    task automatic t_axis;
        wr(msc_pkg::OFS_AXIS, 32'h5);
        cmd(msc_pkg::OP_RT_ON, 16'h0);
        chk(rt_en, 1'b0);
        axis = 8'h05;
        cmd(msc_pkg::OP_RT_ON, 16'h0);
        chk(rt_en, 1'b1);
        cmd(msc_pkg::OP_RT_OFF, 16'h0);
        chk(rt_en, 1'b0);
        wr(msc_pkg::OFS_AXIS, 32'h0);
        axis = 8'h00;
    endtask : t_axis

    task automatic t_power;
        cmd(msc_pkg::OP_POWER, 16'h1);
        chk({power_switch_cmd, snap[1]}, 2'b11);
        cmd(msc_pkg::OP_POWER, 16'h0);
        chk(power_switch_cmd, 1'b0);
        err_pulse();
        rd(msc_pkg::OFS_STAT1, 32'h400);
        cmd(msc_pkg::OP_POWER, 16'h1);
        chk({power_switch_cmd, snap[1]}, 2'b10);
        rd(msc_pkg::OFS_STAT1, 32'h0);
        err_pulse();
        cmd(msc_pkg::OP_CLR_ERR, 16'h0);
        rd(msc_pkg::OFS_STAT1, 32'h0);
        rd(msc_pkg::OFS_STAT2, 32'h1);
    endtask : t_power

    task automatic t_handler;
        wr(msc_pkg::OFS_CFG, 32'h1);
        wr(msc_pkg::OFS_SEQ, 32'h12);
        wr(msc_pkg::OFS_ACC, 32'h1234);
        err_pulse();
        chk(seq_line, msc_pkg::ERR_LABEL);
        rd(msc_pkg::OFS_DEPTH, 32'h1);
        rd(msc_pkg::OFS_STAT2, 32'h5);
        cmd(msc_pkg::OP_CLR_ERR, 16'h0);
        rd(msc_pkg::OFS_STAT2, 32'h4);
        wr(msc_pkg::OFS_ACC, 32'h9);
        cmd(msc_pkg::OP_RT_EXIT, 16'h0);
        chk({rt_en, seq_line}, 17'h10012);
        rd(msc_pkg::OFS_ACC, 32'h1234);
        rd(msc_pkg::OFS_DEPTH, 32'h0);
        wr(msc_pkg::OFS_CFG, 32'h0);
    endtask : t_handler

    // bench depth 4 keeps the overflow case short
    task automatic t_stack;
        for (int i = 0; i < 4; i++) cmd(msc_pkg::OP_CALL, 16'h20 + i[15:0]);
        rd(msc_pkg::OFS_DEPTH, 32'h4);
        cmd(msc_pkg::OP_CALL, 16'h40);
        rd(msc_pkg::OFS_DEPTH, 32'h4);
        rd(msc_pkg::OFS_STAT1, 32'h400);
        rd(msc_pkg::OFS_STAT2, 32'h2);
        cmd(msc_pkg::OP_EXIT, 16'h0);
        chk(seq_line, 16'h22);
        cmd(msc_pkg::OP_FLUSH, 16'h0);
        rd(msc_pkg::OFS_DEPTH, 32'h0);
        cmd(msc_pkg::OP_CLR_ERR, 16'h0);
    endtask : t_stack

    task automatic xf(input logic [7:0] op, input logic [15:0] p, input logic [3:0] d,
                      input logic [7:0] m, input logic f);
        int n;
        n = 0;
        @(posedge clk_i);
        dip <= d;
        repeat (4) @(posedge clk_i);
        cmd(op, p);
        // direction and mask only mean something while a request stands
        if (m == 8'h0) chk(xsnap[9], 1'b0);
        else chk(xsnap, {1'b1, f, m});
        while (xreq !== 1'b0 && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        chk(xreq, 1'b0);
    endtask : xf

    task automatic t_xfer;
        xf(msc_pkg::OP_LOAD, 16'h0, 4'hf, 8'hff, 1'b0);
        xf(msc_pkg::OP_LOAD, 16'h0, 4'h7, 8'h03, 1'b0);
        xf(msc_pkg::OP_LOAD, 16'h1, 4'h7, 8'h03, 1'b0);
        xf(msc_pkg::OP_LOAD, 16'h2, 4'hf, 8'hfc, 1'b0);
        xf(msc_pkg::OP_LOAD, 16'h2, 4'he, 8'h00, 1'b0);
        xf(msc_pkg::OP_STORE, 16'h0, 4'h0, 8'hff, 1'b1);
        xf(msc_pkg::OP_STORE, 16'h1, 4'h0, 8'h03, 1'b1);
        xf(msc_pkg::OP_STORE, 16'h2, 4'h0, 8'hfc, 1'b1);
    endtask : t_xfer

    task automatic t_reboot;
        cmd(msc_pkg::OP_REBOOT, 16'hfe);
        chk(snap[0], 1'b0);
        cmd(msc_pkg::OP_REBOOT, 16'hff);
        chk(snap[0], 1'b1);
    endtask : t_reboot

    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        results();
    end

    initial begin
        {rst_i, cyc, stb, we, err_ev} = 5'b10000;
        {adr, axis, wdat, dip} = '0;
        sel_v = 4'hf;
        mismatches = 0;
        num_checks = 0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_wipe();
        t_axis();
        t_power();
        t_handler();
        t_stack();
        t_xfer();
        t_reboot();
        results();
    end
endmodule : tb_motion_sequence_command_executor
`default_nettype wire
